/* File: logic/spc_bus_cycle.sv */
// One asynchronous write or read bus cycle on the flash pins.
`timescale 1ns/1ns
`default_nettype none
module spc_bus_cycle (
  // Clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // Request
  input  wire logic                      req_valid,
  input  wire logic                      req_write,
  input  wire logic [spc_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [spc_pkg::DATA_W-1:0] req_data,
  output logic                           req_done,
  output logic [spc_pkg::DATA_W-1:0]     rsp_data,
  // Flash pins
  output logic                           ce_n,
  output logic                           we_n,
  output logic                           oe_n,
  output logic [spc_pkg::ADDR_W-1:0]     addr,
  output logic [spc_pkg::DATA_W-1:0]     dq_o,
  output logic                           dq_oe,
  input  wire logic [spc_pkg::DATA_W-1:0] dq_i
);
  import spc_pkg::*;
  typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_PULSE, BC_HOLD} spc_bc_st_t;
  typedef struct packed {
    spc_bc_st_t          st;
    logic [3:0]          cnt;
    logic                wr;
    logic                done;
    logic                ce_n;
    logic                we_n;
    logic                oe_n;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   dq_o;
    logic                dq_oe;
    logic [DATA_W-1:0]   rd;
    logic [DATA_W-1:0]   s1;
    logic [DATA_W-1:0]   s2;
  } spc_bc_t;
  spc_bc_t s_r, s_nxt;
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.s1 = dq_i;
    s_nxt.s2 = s_r.s1;
    unique case (s_r.st)
      BC_IDLE: begin
        if (req_valid) begin
          // Address and data settle before the strobe falls, so both latch edges see stable values.
          s_nxt.st = BC_SETUP;
          s_nxt.cnt = 4'(SETUP_CYC);
          s_nxt.wr = req_write;
          s_nxt.addr = req_addr;
          s_nxt.dq_o = req_data;
          s_nxt.dq_oe = req_write;
          s_nxt.ce_n = 1'b0;
        end
      end
      BC_SETUP: begin
        s_nxt.cnt = s_r.cnt - 4'h1;
        if (s_r.cnt == 4'h1) begin
          s_nxt.st = BC_PULSE;
          s_nxt.cnt = 4'(PULSE_CYC + 2);
          s_nxt.we_n = ~s_r.wr;
          s_nxt.oe_n = s_r.wr;
        end
      end
      BC_PULSE: begin
        s_nxt.cnt = s_r.cnt - 4'h1;
        if (s_r.cnt == 4'h1) begin
          s_nxt.st = BC_HOLD;
          s_nxt.cnt = 4'(HOLD_CYC);
          s_nxt.rd = s_r.s2;
          s_nxt.we_n = 1'b1;
          s_nxt.oe_n = 1'b1;
        end
      end
      BC_HOLD: begin
        s_nxt.cnt = s_r.cnt - 4'h1;
        if (s_r.cnt == 4'h1) begin
          s_nxt.st = BC_IDLE;
          s_nxt.ce_n = 1'b1;
          s_nxt.dq_oe = 1'b0;
          s_nxt.done = 1'b1;
        end
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.ce_n <= 1'b1;
      s_r.we_n <= 1'b1;
      s_r.oe_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign req_done = s_r.done;
  assign rsp_data = s_r.rd;
  assign ce_n = s_r.ce_n;
  assign we_n = s_r.we_n;
  assign oe_n = s_r.oe_n;
  assign addr = s_r.addr;
  assign dq_o = s_r.dq_o;
  assign dq_oe = s_r.dq_oe;
endmodule : spc_bus_cycle
`default_nettype wire

/* File: logic/spc_host.sv */
// Host controller that runs sector guard command sequences for software over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module spc_host (
  // Clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // AXI4-Lite write address and data
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [5:0]                 s_axi_awaddr,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  // AXI4-Lite write response
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  output logic [1:0]                      s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  input  wire logic [5:0]                 s_axi_araddr,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  // Flash pins
  output logic                            ce_n,
  output logic                            we_n,
  output logic                            oe_n,
  output logic [spc_pkg::ADDR_W-1:0]      addr,
  output logic [spc_pkg::DATA_W-1:0]      dq_o,
  output logic                            dq_oe,
  input  wire logic [spc_pkg::DATA_W-1:0] dq_i,
  output logic                            acceleration_pin
);
  import spc_pkg::*;
  localparam int SEQ_MAX = 16;
  typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_WAIT} spc_hst_t;
  typedef struct packed {
    spc_hst_t            st;
    logic                aw_got;
    logic                w_got;
    logic [5:0]          awaddr;
    logic [31:0]         wdata;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    logic [3:0]          op;
    logic [ADDR_W-1:0]   arg_addr;
    logic [DATA_W-1:0]   arg_data;
    logic [63:0]         pw;
    logic [DATA_W-1:0]   rd;
    logic [63:0]         pw_rd;
    logic                busy;
    logic                done;
    logic                bad_op;
    logic [4:0]          step;
    logic [4:0]          last;
    logic                accel;
  } spc_host_t;
  spc_host_t s_r, s_nxt;
  logic                 bc_done;
  logic [DATA_W-1:0]    bc_rd;
  logic                 bc_valid;
  logic                 bc_write;
  logic [ADDR_W-1:0]    bc_addr;
  logic [DATA_W-1:0]    bc_data;

  // Length of each sequence, entry and exit included, minus one.
  function automatic logic [4:0] seq_last(input logic [3:0] op);
    unique case (spc_op_t'(op))
      SPC_OP_PW_READ:    seq_last = 5'd12;
      SPC_OP_PW_UNLOCK:  seq_last = 5'd15;
      SPC_OP_RESET:      seq_last = 5'd0;
      SPC_OP_ARRAY_READ: seq_last = 5'd0;
      SPC_OP_LOCK_READ, SPC_OP_PERS_READ, SPC_OP_FRZ_READ, SPC_OP_VOL_READ: seq_last = 5'd5;
      default:           seq_last = 5'd6;
    endcase
  endfunction

  function automatic logic [7:0] mode_code(input logic [3:0] op);
    unique case (spc_op_t'(op))
      SPC_OP_LOCK_PROG, SPC_OP_LOCK_READ:                     mode_code = MODE_LOCK;
      SPC_OP_PW_PROG, SPC_OP_PW_READ, SPC_OP_PW_UNLOCK:       mode_code = MODE_PASS;
      SPC_OP_PERS_PROG, SPC_OP_PERS_ERASE, SPC_OP_PERS_READ: mode_code = MODE_PERS;
      SPC_OP_FRZ_SET, SPC_OP_FRZ_READ:                        mode_code = MODE_FRZ;
      default:                                                mode_code = MODE_VOL;
    endcase
  endfunction

  // Step table: {write, address, data} for bus cycle n of the current operation.
  function automatic logic [ADDR_W+DATA_W:0] seq_step(input spc_host_t s, input logic [4:0] n);
    logic [ADDR_W-1:0] a0;
    logic [ADDR_W-1:0] pa;
    logic [2:0]        bi;
    logic [4:0]        ex;
    a0 = '0;
    pa = ADDR_W'(n - 5'd3);
    bi = 3'(n - 5'd5);
    ex = s.last - 5'd1;
    seq_step = {1'b1, a0, CMD_EXIT2};
    if (spc_op_t'(s.op) == SPC_OP_RESET) begin
      seq_step = {1'b1, a0, CMD_RESET};
    end else if (spc_op_t'(s.op) == SPC_OP_ARRAY_READ) begin
      seq_step = {1'b0, s.arg_addr, 8'h00};
    end else if (n == 5'd0) begin
      seq_step = {1'b1, ADDR_W'(ADR_UNLK1), DAT_UNLK1};
    end else if (n == 5'd1) begin
      seq_step = {1'b1, ADDR_W'(ADR_UNLK2), DAT_UNLK2};
    end else if (n == 5'd2) begin
      seq_step = {1'b1, ADDR_W'(ADR_UNLK1), mode_code(s.op)};
    end else if (n == ex) begin
      seq_step = {1'b1, a0, CMD_EXIT1};
    end else if (n == s.last) begin
      seq_step = {1'b1, a0, CMD_EXIT2};
    end else begin
      unique case (spc_op_t'(s.op))
        SPC_OP_LOCK_PROG, SPC_OP_FRZ_SET:
          seq_step = (n == 5'd3) ? {1'b1, a0, CMD_PROG} : {1'b1, a0, s.arg_data};
        SPC_OP_PW_PROG:
          seq_step = (n == 5'd3) ? {1'b1, a0, CMD_PROG} : {1'b1, s.arg_addr, s.arg_data};
        SPC_OP_PERS_PROG, SPC_OP_VOL_SET:
          seq_step = (n == 5'd3) ? {1'b1, a0, CMD_PROG} : {1'b1, s.arg_addr, DAT_SET};
        SPC_OP_VOL_CLR:
          seq_step = (n == 5'd3) ? {1'b1, a0, CMD_PROG} : {1'b1, s.arg_addr, DAT_CLR};
        SPC_OP_PERS_ERASE:
          seq_step = (n == 5'd3) ? {1'b1, a0, CMD_ERA1} : {1'b1, a0, CMD_ERA2};
        SPC_OP_LOCK_READ, SPC_OP_FRZ_READ:
          seq_step = {1'b0, a0, 8'h00};
        SPC_OP_PERS_READ, SPC_OP_VOL_READ:
          seq_step = {1'b0, s.arg_addr, 8'h00};
        SPC_OP_PW_READ:
          seq_step = {1'b0, pa, 8'h00};
        SPC_OP_PW_UNLOCK: begin
          if (n == 5'd3) begin
            seq_step = {1'b1, a0, CMD_UNL1};
          end else if (n == 5'd4) begin
            seq_step = {1'b1, a0, CMD_UNL2};
          end else if (n == 5'd13) begin
            seq_step = {1'b1, a0, CMD_UNL3};
          end else begin
            seq_step = {1'b1, ADDR_W'(bi), s.pw[8*bi +: 8]};
          end
        end
        default: seq_step = {1'b1, a0, CMD_RESET};
      endcase
    end
  endfunction

  logic [ADDR_W+DATA_W:0] cur;
  always_comb begin
    cur = seq_step(s_r, s_r.step);
    bc_valid = (s_r.st == H_ISSUE);
    bc_write = cur[ADDR_W+DATA_W];
    bc_addr = cur[ADDR_W+DATA_W-1:DATA_W];
    bc_data = cur[DATA_W-1:0];
  end

  always_comb begin
    logic [31:0] wd;
    wd = s_r.wdata;
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    // Write channel: address and data may arrive in either order.
    if (s_axi_awvalid && !s_r.aw_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.w_got && !s_r.bvalid) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      wd = s_axi_wdata;
    end
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      unique case ({s_r.awaddr[5:2], 2'b00})
        REG_CTRL: begin
          // A start while busy is refused so a running sequence is never torn.
          if (s_r.wdata[CTRL_GO_BIT] && !s_r.busy && s_r.wdata[3:0] <= 4'(SPC_OP_ARRAY_READ)) begin
            s_nxt.op = s_r.wdata[CTRL_OP_LSB +: 4];
            s_nxt.busy = 1'b1;
            s_nxt.bad_op = 1'b0;
            s_nxt.step = '0;
            s_nxt.last = seq_last(s_r.wdata[3:0]);
            s_nxt.st = H_ISSUE;
            s_nxt.accel = 1'b1;
          end else if (s_r.wdata[CTRL_GO_BIT]) begin
            s_nxt.bad_op = 1'b1;
          end
        end
        REG_ADDR:  if (s_axi_wstrb != 4'h0) s_nxt.arg_addr = s_r.wdata[ADDR_W-1:0];
        REG_WDATA: if (s_axi_wstrb[0]) s_nxt.arg_data = s_r.wdata[7:0];
        REG_PWLO:  s_nxt.pw[31:0] = s_r.wdata;
        REG_PWHI:  s_nxt.pw[63:32] = s_r.wdata;
        default:   s_nxt.bresp = RESP_SLVERR;
      endcase
    end
    if (s_r.bvalid && s_axi_bready) s_nxt.bvalid = 1'b0;
    // Read channel.
    if (s_axi_arvalid && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      unique case ({s_axi_araddr[5:2], 2'b00})
        REG_CTRL:   s_nxt.rdata = {28'h0000000, s_r.op};
        REG_ADDR:   s_nxt.rdata = 32'(s_r.arg_addr);
        REG_WDATA:  s_nxt.rdata = {24'h000000, s_r.arg_data};
        REG_STATUS: s_nxt.rdata = {29'h00000000, s_r.bad_op, s_r.done, s_r.busy};
        REG_RDATA:  s_nxt.rdata = {24'h000000, s_r.rd};
        REG_PWLO:   s_nxt.rdata = s_r.pw_rd[31:0];
        REG_PWHI:   s_nxt.rdata = s_r.pw_rd[63:32];
        default: begin
          s_nxt.rdata = 32'h00000000;
          s_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (s_r.rvalid && s_axi_rready) s_nxt.rvalid = 1'b0;
    // Sequencer.
    unique case (s_r.st)
      H_IDLE: ;
      H_ISSUE: s_nxt.st = H_WAIT;
      H_WAIT: begin
        if (bc_done) begin
          if (!bc_write) begin
            s_nxt.rd = bc_rd;
            if (spc_op_t'(s_r.op) == SPC_OP_PW_READ) begin
              // The byte index must wrap at three bits, so the sum is sized before it is scaled.
              s_nxt.pw_rd[8*3'(s_r.step[2:0] + 3'h5) +: 8] = bc_rd;
            end
          end
          if (s_r.step == s_r.last) begin
            s_nxt.st = H_IDLE;
            s_nxt.busy = 1'b0;
            s_nxt.accel = 1'b0;
            s_nxt.done = 1'b1;
          end else begin
            s_nxt.step = s_r.step + 5'd1;
            s_nxt.st = H_ISSUE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  spc_bus_cycle u_cycle (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .req_valid (bc_valid),
    .req_write (bc_write),
    .req_addr  (bc_addr),
    .req_data  (bc_data),
    .req_done  (bc_done),
    .rsp_data  (bc_rd),
    .ce_n      (ce_n),
    .we_n      (we_n),
    .oe_n      (oe_n),
    .addr      (addr),
    .dq_o      (dq_o),
    .dq_oe     (dq_oe),
    .dq_i      (dq_i)
  );

  assign s_axi_awready = s_r.aw_got;
  assign s_axi_wready = s_r.w_got;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign acceleration_pin = s_r.accel;
endmodule : spc_host
`default_nettype wire

/* File: logic/spc_pkg.sv */
// Package of constants and types for the sector guard command host controller.
// Summary of operation
// - Enter mode with AA, 55, mode code.
// - Password byte program: A0 then byte.
// - Password read is eight reads, 00 to 07.
// - Password bytes live at addresses 00-07.
// - Unlock: 25, 03, eight bytes, 29.
// - Persistent guard program: A0 then 00 at sector.
// - Freeze mode: A0, 00 sets; read returns bit.
// - Volatile guard: A0 then 00 set, 01 clear.
// - Leave mode with 90 then 00.
// - Host issues reset (F0) only when software starts the reset op.
`default_nettype none
package spc_pkg;
  localparam int ADDR_W = 23;
  localparam int DATA_W = 8;
  // Command addresses and data bytes.
  localparam logic [11:0] ADR_UNLK1 = 12'hAAA;
  localparam logic [11:0] ADR_UNLK2 = 12'h555;
  localparam logic [7:0]  DAT_UNLK1 = 8'hAA;
  localparam logic [7:0]  DAT_UNLK2 = 8'h55;
  localparam logic [7:0]  MODE_LOCK = 8'h40;
  localparam logic [7:0]  MODE_PASS = 8'h60;
  localparam logic [7:0]  MODE_PERS = 8'hC0;
  localparam logic [7:0]  MODE_FRZ  = 8'h50;
  localparam logic [7:0]  MODE_VOL  = 8'hE0;
  localparam logic [7:0]  CMD_PROG  = 8'hA0;
  localparam logic [7:0]  CMD_ERA1  = 8'h80;
  localparam logic [7:0]  CMD_ERA2  = 8'h30;
  localparam logic [7:0]  CMD_UNL1  = 8'h25;
  localparam logic [7:0]  CMD_UNL2  = 8'h03;
  localparam logic [7:0]  CMD_UNL3  = 8'h29;
  localparam logic [7:0]  CMD_EXIT1 = 8'h90;
  localparam logic [7:0]  CMD_EXIT2 = 8'h00;
  localparam logic [7:0]  CMD_RESET = 8'hF0;
  localparam logic [7:0]  DAT_SET   = 8'h00;
  localparam logic [7:0]  DAT_CLR   = 8'h01;
  localparam logic [2:0]  PW_BYTES_M1 = 3'h7;
  // Bus cycle timing in 10 ns clocks.
  localparam int CLK_NS     = 10;
  localparam int SETUP_NS   = 30;
  localparam int PULSE_NS   = 50;
  localparam int HOLD_NS    = 30;
  localparam int SETUP_CYC  = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC  = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC   = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  // Register byte offsets.
  localparam logic [5:0] REG_CTRL   = 6'h00;
  localparam logic [5:0] REG_ADDR   = 6'h04;
  localparam logic [5:0] REG_WDATA  = 6'h08;
  localparam logic [5:0] REG_STATUS = 6'h0C;
  localparam logic [5:0] REG_RDATA  = 6'h10;
  localparam logic [5:0] REG_PWLO   = 6'h14;
  localparam logic [5:0] REG_PWHI   = 6'h18;
  // Control register fields.
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_GO_BIT = 31;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [3:0] {
    SPC_OP_LOCK_PROG, SPC_OP_LOCK_READ, SPC_OP_PW_PROG, SPC_OP_PW_READ,
    SPC_OP_PW_UNLOCK, SPC_OP_PERS_PROG, SPC_OP_PERS_ERASE, SPC_OP_PERS_READ,
    SPC_OP_FRZ_SET, SPC_OP_FRZ_READ, SPC_OP_VOL_SET, SPC_OP_VOL_CLR,
    SPC_OP_VOL_READ, SPC_OP_RESET, SPC_OP_ARRAY_READ
  } spc_op_t;
endpackage : spc_pkg
`default_nettype wire

/* File: test/spc_flash_model.sv */
// Behavioural flash device that answers sector guard command sequences.
`timescale 1ns/1ns
`default_nettype none
module spc_flash_model (
  // Flash pins
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [22:0] addr,
  input  wire logic [7:0]  dq_o,
  input  wire logic        accel,
  // Read data
  output logic      [7:0]  dq_i
);
  localparam int SL = 16;
  logic [7:0] mode, lock, last, rdv, pw [8];
  logic [63:0] pers, vol;
  logic [3:0] st, n;
  logic [7:0] seen;
  logic [22:0] la;
  logic frz, ok, unl, accel_err;
  int resets;
  initial begin
    mode = 0; st = 0; lock = 8'hFF; pers = 0; vol = 0; frz = 0; unl = 0;
    accel_err = 0; resets = 0; last = 0;
    foreach (pw[i]) pw[i] = 8'hFF;
  end
  always @(negedge (we_n | ce_n)) la = addr;
  always @(posedge (we_n | ce_n)) begin
    if (dq_o == 8'hF0) begin
      mode = 0;
      st = 0;
      resets++;
    end else if (mode == 0) begin
      if (st == 0 && la[11:0] == 12'hAAA && dq_o == 8'hAA) st = 1;
      else if (st == 1 && la[11:0] == 12'h555 && dq_o == 8'h55) st = 2;
      else if (st == 2 && la[11:0] == 12'hAAA) begin
        mode = dq_o;
        st = 0;
      end else st = 0;
    end else case (st)
      // A command foreign to the mode leaves the device stuck until F0.
      0: st = dq_o == 8'hA0 ? 1 : dq_o == 8'h90 ? 9 : (dq_o == 8'h80 && mode == 8'hC0) ? 2 :
              (dq_o == 8'h25 && mode == 8'h60) ? 3 : 15;
      1: begin
        st = 0;
        if ((mode == 8'hC0 || mode == 8'hE0) && !accel) accel_err = 1;
        case (mode)
          8'h40: lock = dq_o;
          8'h60: pw[la[2:0]] = dq_o;
          8'hC0: if (dq_o == 0) pers[la[SL+:6]] = 1;
          8'h50: if (dq_o == 0) frz = 1;
          8'hE0: vol[la[SL+:6]] = dq_o == 0;
          default: st = 15;
        endcase
      end
      2: begin
        st = dq_o == 8'h30 ? 0 : 15;
        if (st == 0) begin
          pers = '1;
          pers = '0;
        end
      end
      3: begin
        st = dq_o == 8'h03 ? 4 : 15;
        ok = 1;
        n = 0;
        seen = 0;
      end
      4: begin
        ok = ok && pw[la[2:0]] == dq_o;
        seen[la[2:0]] = 1;
        n++;
        if (n == 8) st = 5;
      end
      5: begin
        unl = ok && &seen && dq_o == 8'h29;
        st = 0;
      end
      9: begin
        st = dq_o == 0 ? 0 : 15;
        if (dq_o == 0) mode = 0;
      end
      default: ;
    endcase
  end
  always @* begin
    case (mode)
      8'h40: rdv = lock;
      8'h60: rdv = addr[22:3] == 0 ? pw[addr[2:0]] : 8'hFF;
      8'hC0: rdv = {7'h0, !pers[addr[SL+:6]]};
      8'h50: rdv = {7'h0, !frz};
      8'hE0: rdv = {7'h0, !vol[addr[SL+:6]]};
      default: rdv = addr[7:0] ^ 8'h5A;
    endcase
  end
  // A released bus shows the inverse of its last value, never a stale copy.
  always @(ce_n, oe_n, rdv) begin
    if (!ce_n && !oe_n) begin
      dq_i = rdv;
      last = rdv;
    end else dq_i = ~last;
  end
endmodule  // spc_flash_model
`default_nettype wire

/* File: test/spc_host_chk.sv */
// Checker of flash strobe and bus handshake relations at the host ports.
`timescale 1ns/1ns
`default_nettype none
module spc_host_chk (
  // Clock and reset
  input wire logic                  aclk,
  input wire logic                  aresetn,
  // Bus answers
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_arready,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire logic [31:0]           s_axi_rdata,
  // Flash pins
  input wire logic                  ce_n,
  input wire logic                  we_n,
  input wire logic                  oe_n,
  input wire logic [spc_pkg::ADDR_W-1:0] addr,
  input wire logic [spc_pkg::DATA_W-1:0] dq_o,
  input wire logic                  dq_oe,
  input wire logic                  acceleration_pin
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_strobe_excl: assert property (!(!we_n && !oe_n)) else $error("both strobes low");
  a_we_in_ce: assert property (!we_n |-> !ce_n && dq_oe) else $error("write outside select");
  a_oe_no_drive: assert property (!oe_n |-> !ce_n && !dq_oe) else $error("read while driving");
  a_we_setup: assert property ($fell(we_n) |-> $past(!ce_n, 3)) else $error("write setup short");
  a_we_pulse: assert property ($fell(we_n) |-> !we_n [*5]) else $error("write pulse short");
  a_latch_hold: assert property (!we_n |=> $stable(addr) && $stable(dq_o)) else $error("moved in pulse");
  a_ce_tail: assert property ($rose(we_n) && $past(aresetn) |-> !ce_n [*3] ##1 ce_n) else $error("ce tail");
  a_acc_write: assert property (!we_n |-> acceleration_pin) else $error("acceleration low");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_ar_pair: assert property (s_axi_arready |-> $rose(s_axi_rvalid)) else $error("arready unpaired");
  a_reset_idle: assert property (disable iff (1'b0) !aresetn |=> ce_n && we_n && oe_n && !dq_oe)
    else $error("pins busy after reset");
  cover property ($fell(we_n));
  cover property ($fell(oe_n));
  cover property (s_axi_bvalid && s_axi_bready);
endmodule  // spc_host_chk
bind spc_host spc_host_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .ce_n(ce_n),
  .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_o(dq_o), .dq_oe(dq_oe), .acceleration_pin(acceleration_pin));
`default_nettype wire

/* File: test/test_sector_protect_command_decoder.sv */
// Testbench driving the sector guard host controller against the flash model.
`timescale 1ns/1ns
`default_nettype none
module test_sector_protect_command_decoder;
  import spc_pkg::*;
  logic aclk, aresetn, awv, wv, bry, arv, rry;
  logic [5:0] awa, ara;
  logic [31:0] wd, v;
  logic [1:0] r;
  wire logic awr, wr, bv, arr, rv, ce_n, we_n, oe_n, dq_oe, accel;
  wire logic [1:0] br, rr;
  wire logic [31:0] rd;
  wire logic [ADDR_W-1:0] addr;
  wire logic [DATA_W-1:0] dq_o, dq_i;
  int errors, cmp_count, cyc;
  localparam logic [63:0] PW = 64'hA1B2C3D4E5F60718;
  spc_host u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i),
    .acceleration_pin(accel));
  spc_flash_model u_flash (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_o(dq_o),
    .accel(accel), .dq_i(dq_i));
  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  task automatic test_done;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // The ceiling sits well above the longest sequence so a hang, not a slow op, trips it.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      test_done;
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic ta, tw, tb;
    awa <= a; wd <= d; awv <= 1'h1; wv <= 1'h1; bry <= 1'h1;
    do begin
      @(negedge aclk);
      ta = awr; tw = wr; tb = bv; rs = br;
      @(posedge aclk);
      if (ta) awv <= 1'h0;
      if (tw) wv <= 1'h0;
    end while (!tb);
    bry <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic rd_reg(input logic [5:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic ta, tr;
    ara <= a; arv <= 1'h1; rry <= 1'h1;
    do begin
      @(negedge aclk);
      ta = arr; tr = rv; d = rd; rs = rr;
      @(posedge aclk);
      if (ta) arv <= 1'h0;
    end while (!tr);
    rry <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic op(input logic [3:0] o, input logic [22:0] a, input logic [7:0] d);
    logic [31:0] s;
    logic [1:0] q;
    int k;
    wr_reg(REG_ADDR, {9'h0, a}, q);
    wr_reg(REG_WDATA, {24'h0, d}, q);
    wr_reg(REG_CTRL, {1'h1, 27'h0, o}, q);
    k = 0;
    do begin
      rd_reg(REG_STATUS, s, q);
      k++;
    end while (s[0] !== 1'h0 && k < 2000);
    chk("busy", 0, {31'h0, s[0]});
    chk("mode", 0, {24'h0, u_flash.mode});
  endtask
  task automatic rdat(input string nm, input logic [31:0] exp);
    rd_reg(REG_RDATA, v, r);
    chk(nm, exp, v);
  endtask
  task automatic t_array_lock;
    op(4'hE, 23'h012345, 8'h00);
    rdat("array", 32'h1F);
    op(4'h0, 23'h0, 8'h3C);
    chk("lock", 32'h3C, {24'h0, u_flash.lock});
    op(4'h1, 23'h0, 8'h00);
    rdat("lockrd", 32'h3C);
  endtask
  task automatic t_password;
    for (int i = 0; i < 8; i++) op(4'h2, 23'(i), PW[8*i+:8]);
    op(4'h3, 23'h0, 8'h00);
    rd_reg(REG_PWLO, v, r);
    chk("pwlo", PW[31:0], v);
    rd_reg(REG_PWHI, v, r);
    chk("pwhi", PW[63:32], v);
    wr_reg(REG_PWLO, PW[31:0], r);
    wr_reg(REG_PWHI, PW[63:32], r);
    op(4'h4, 23'h0, 8'h00);
    chk("unlock", 1, {31'h0, u_flash.unl});
    wr_reg(REG_PWHI, PW[63:32] ^ 32'h1, r);
    op(4'h4, 23'h0, 8'h00);
    chk("badpw", 0, {31'h0, u_flash.unl});
  endtask
  task automatic t_guards;
    op(4'h5, 23'h031234, 8'h00);
    op(4'h7, 23'h03FFFF, 8'h00);
    rdat("pers3", 32'h0);
    op(4'h7, 23'h040000, 8'h00);
    rdat("pers4", 32'h1);
    op(4'h6, 23'h0, 8'h00);
    op(4'h7, 23'h030000, 8'h00);
    rdat("erased", 32'h1);
    op(4'h9, 23'h0, 8'h00);
    rdat("frz0", 32'h1);
    op(4'h8, 23'h0, 8'h00);
    op(4'h9, 23'h0, 8'h00);
    rdat("frz1", 32'h0);
    op(4'hA, 23'h05ABCD, 8'h00);
    op(4'hC, 23'h050000, 8'h00);
    rdat("volset", 32'h0);
    op(4'hB, 23'h05FFFF, 8'h00);
    op(4'hC, 23'h050000, 8'h00);
    rdat("volclr", 32'h1);
    chk("accel", 0, {31'h0, u_flash.accel_err});
  endtask
  task automatic t_misc;
    int n0;
    n0 = u_flash.resets;
    op(4'hD, 23'h0, 8'h00);
    chk("reset", n0 + 1, u_flash.resets);
    wr_reg(REG_CTRL, {1'h1, 27'h0, 4'hF}, r);
    rd_reg(REG_STATUS, v, r);
    chk("badop", 1, {31'h0, v[2]});
    wr_reg(6'h20, 32'h0, r);
    chk("wresp", RESP_SLVERR, r);
    rd_reg(6'h24, v, r);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("rdata_err", 32'h0, v);
  endtask
  initial begin
    errors = 0; cmp_count = 0; cyc = 0; aresetn = 0;
    awv = 0; wv = 0; bry = 0; arv = 0; rry = 0; awa = 0; ara = 0; wd = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_array_lock;
    t_password;
    t_guards;
    t_misc;
    test_done;
  end
endmodule  // test_sector_protect_command_decoder
`default_nettype wire
